// [dv/dpdcs_master_model.sv]
// master-side model collecting the transmit datagram bytes
`timescale 1ns/10ps
`default_nettype none
module dpdcs_master_model (
  // clock
  input wire logic i_clk,
  // datagram stream from the bank
  input wire logic i_valid,
  input wire logic [7:0] i_byte,
  input wire logic i_last
);
  logic [7:0] bytes [0:31];
  int n;
  logic done;
  // empties the capture before a new cycle
  task automatic clear();
    n = 0;
    done = 1'b0;
  endtask
  // bytes land from index zero in arrival order
  always @(posedge i_clk) begin
    if (i_valid) begin
      bytes[n[4:0]] <= i_byte;
      n <= n + 1;
      done <= i_last;
    end
  end
endmodule // dpdcs_master_model
`default_nettype wire

// [dv/tb_dpdcs_core.sv]
// self-checking bench of the process data and command/state word bank
`timescale 1ns/10ps
`default_nettype none
module tb_dpdcs_core import dpdcs_pkg::*;;
  logic clk = 1'b0, rst = 1'b1, req = 1'b0, rxv = 1'b0, start = 1'b0;
  logic ext = 1'b0, prof = 1'b1;
  logic [1:0] mode = 2'h0;
  logic [15:0] rxw = 16'h0000;
  dpdcs_obj_req_t obj = '0;
  dpdcs_items_t items = '0;
  dpdcs_flags_t flags = '0;
  dpdcs_bypass_t byp = '{16'h00a3, 16'h0134, 16'h03e8};
  logic ack, err, dv, dlast, dbusy, volt, permit, run, qs, alr, flt;
  logic [15:0] rdata;
  logic [7:0] dbyte;
  logic [15:0] e16 [0:6];
  int miscompares = 0, compares = 0, cyc = 0;
  dpdcs_core dpdcs_core_i (.i_clk(clk), .i_rst(rst), .i_obj_req(req),
    .i_obj(obj), .o_obj_ack(ack), .o_obj_err(err), .o_obj_rdata(rdata),
    .i_rx_cmd_valid(rxv), .i_rx_cmd_word(rxw), .i_dg_start(start),
    .o_dg_valid(dv), .o_dg_byte(dbyte), .o_dg_last(dlast), .o_dg_busy(dbusy),
    .i_items(items), .i_ext_support(ext), .i_flags(flags), .i_bypass(byp),
    .i_profile_mode(prof), .i_drive_ctrl_mode(mode),
    .o_output_voltage_enable(volt), .o_start_permit(permit),
    .o_run_enable_cmd(run), .o_quick_stop_bit(qs), .o_alert_reset_cmd(alr),
    .o_fault_reset_cmd(flt));
  dpdcs_master_model dpdcs_master_model_i (.i_clk(clk), .i_valid(dv),
    .i_byte(dbyte), .i_last(dlast));
  // 25 MHz clock
  always #20 clk = ~clk;
  // cut a hang short; the tests need well under this many cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one access: request for one cycle, answer expected the next cycle
  task automatic acc(input logic wr, input logic [15:0] idx,
    input logic [7:0] sub, input logic [15:0] wd, input logic xerr,
    input logic [15:0] xrd);
    @(posedge clk);
    req <= 1'b1;
    obj <= '{wr, idx, sub, wd};
    @(posedge clk);
    req <= 1'b0;
    #1;
    chk({15'h0, ack}, 16'h0001);
    chk({15'h0, err}, {15'h0, xerr});
    chk(rdata, xrd);
  endtask
  // write the command word and count reset pulses over four cycles
  task automatic cmd(input logic [15:0] cw, input int xa, input int xf);
    int na, nf;
    na = 0;
    nf = 0;
    acc(1'b1, IDX_CMD_WORD, SUB_ZERO, cw, 1'b0, 16'h0000);
    repeat (4) begin
      if (alr === 1'b1) na++;
      if (flt === 1'b1) nf++;
      @(posedge clk);
      #1;
    end
    chk(na[15:0], xa[15:0]);
    chk(nf[15:0], xf[15:0]);
  endtask
  // expected state word; unused bits stay zero
  function automatic logic [15:0] sw_exp(input dpdcs_flags_t f,
    input logic [1:0] m);
    return {1'b0, m != CTRL_MODE_PROFILE, 3'b000, f.target_reached,
      f.remote, 1'b0, f.alarm, f.switch_on_disabled, f.quick_stop_active,
      f.voltage_enabled, f.fault, f.op_enabled, f.switched_on, f.ready};
  endfunction
  initial begin
    for (int i = 0; i < 16; i++) items[i] = 16'h03e9 + 16'(i);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // state word flags and mode mismatch, two opposite patterns
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      flags <= k ? 10'h155 : 10'h2aa;
      mode <= k[1:0];
      @(posedge clk);
      acc(1'b0, IDX_STATE_WORD, SUB_ZERO, 16'h0, 1'b0, sw_exp(flags, mode));
      acc(1'b0, IDX_MAP_STATE, SUB_FIRST, 16'h0, 1'b0, sw_exp(flags, mode));
    end
    acc(1'b1, IDX_STATE_WORD, SUB_ZERO, 16'hffff, 1'b1, 16'h0000);
    $display("state word test done");
    // reset edges, steady level, start chain, unused bits
    cmd(16'h0800, 1, 0);
    cmd(16'h0800, 0, 0);
    cmd(16'h0880, 0, 1);
    cmd(16'h000b, 0, 0);
    chk({12'h0, volt, permit, run, qs}, 16'h000e);
    cmd(16'hf774, 0, 0);
    chk({12'h0, volt, permit, run, qs}, 16'h0001);
    acc(1'b0, IDX_CMD_WORD, SUB_ZERO, 16'h0, 1'b0, 16'hf774);
    @(posedge clk);
    rxv <= 1'b1;
    rxw <= 16'h0003;
    @(posedge clk);
    rxv <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({12'h0, volt, permit, run, qs}, 16'h000c);
    @(posedge clk);
    prof <= 1'b0;
    acc(1'b0, IDX_CMD_WORD, SUB_ZERO, 16'h0, 1'b1, 16'h0000);
    chk({12'h0, volt, permit, run, qs}, 16'h0000);
    acc(1'b1, IDX_CMD_WORD, SUB_ZERO, 16'h0003, 1'b1, 16'h0000);
    chk({12'h0, volt, permit, run, qs}, 16'h0000);
    $display("command word test done");
    // items by dictionary and by mapping, narrow then wide drive
    for (int x = 0; x < 2; x++) begin
      @(posedge clk);
      ext <= x[0];
      for (int n = 1; n <= 16; n++) begin
        e16[0] = (n > 8 && x == 0) ? 16'h0000 : items[n-1];
        acc(1'b0, IDX_ITEMS, 8'(n), 16'h0, 1'b0, e16[0]);
        acc(1'b0, IDX_MAP_ITEM1 + 16'((n - 1) / 4), 8'((n - 1) % 4 + 1),
          16'h0, 1'b0, e16[0]);
      end
    end
    acc(1'b0, IDX_MAP_ITEM1, SUB_ZERO, 16'h0, 1'b0, 16'h0004);
    acc(1'b1, IDX_ITEMS, SUB_FIRST, 16'h1234, 1'b1, 16'h0000);
    acc(1'b0, IDX_MAP_BYPASS, 8'h03, 16'h0, 1'b0, byp.speed_actual);
    $display("item test done");
    // assignment in master order, then one datagram
    acc(1'b1, IDX_RX_ASSIGN, SUB_ZERO, 16'h0000, 1'b0, 16'h0000);
    acc(1'b1, IDX_TX_ASSIGN, SUB_ZERO, 16'h0000, 1'b0, 16'h0000);
    acc(1'b1, IDX_TX_ASSIGN, 8'h01, IDX_MAP_ITEM1, 1'b0, 16'h0000);
    acc(1'b1, IDX_TX_ASSIGN, 8'h02, IDX_MAP_BYPASS, 1'b0, 16'h0000);
    acc(1'b1, IDX_TX_ASSIGN, SUB_ZERO, 16'h0007, 1'b1, 16'h0000);
    acc(1'b1, IDX_TX_ASSIGN, SUB_ZERO, 16'h0002, 1'b0, 16'h0000);
    acc(1'b1, IDX_TX_ASSIGN, 8'h01, IDX_MAP_BYPASS, 1'b1, 16'h0000);
    acc(1'b0, IDX_TX_ASSIGN, 8'h01, 16'h0, 1'b0, IDX_MAP_ITEM1);
    dpdcs_master_model_i.clear();
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    #1;
    chk({15'h0, dbusy}, 16'h0001);
    for (int w = 0; w < 40 && dpdcs_master_model_i.done !== 1'b1; w++)
      @(posedge clk);
    #1;
    chk({15'h0, dbusy}, 16'h0000);
    chk({15'h0, dpdcs_master_model_i.done}, 16'h0001);
    for (int i = 0; i < 4; i++) e16[i] = items[i];
    e16[4] = byp.fixed_status;
    e16[5] = byp.general_status;
    e16[6] = byp.speed_actual;
    chk(16'(dpdcs_master_model_i.n), 16'h000e);
    for (int i = 0; i < 7; i++) begin
      chk({8'h0, dpdcs_master_model_i.bytes[2*i]}, {8'h0, e16[i][7:0]});
      chk({8'h0, dpdcs_master_model_i.bytes[2*i+1]}, {8'h0, e16[i][15:8]});
    end
    $display("datagram test done");
    complete_run();
  end
endmodule // tb_dpdcs_core
`default_nettype wire

// [verilog/dpdcs_core.sv]
// process data out, command word and state word bank of the drive interface
//
// Behaviour
// - each item mapping object holds four 16-bit items in consecutive subs
// - eight items always exist; nine to sixteen need the wide drive modes
// - items nine to sixteen read zero when the drive supplies only eight
// - items are read-only via maps 1a01-1a04 and index 5fff, both modes
// - assigned items go out in order from byte zero, low byte first
// - bypass map carries fixed status, general status, actual speed
// - rising edge of command bit 11 resets the alarm, level does nothing
// - rising edge of command bit 7 resets the fault
// - bit 1 enables voltage, bit 0 permits start with it, bit 3 starts
// - command bit 2 requests the configured quick stop
// - command bits 4-6, 8-10 and 12-15 have no function
// - command word is read-write at 6040, profile mode only
// - state word is read-only at 6041, profile mode only
// - state bit 14 flags a drive control mode not matching the profile
// - state bit 9 shows fieldbus control, bit 10 target reached
// - state bit 7 shows active alarm, bit 3 a fault
// - state bits 0,1,2,4,5,6 show the drive state machine flags
// - state bits 8, 11, 12, 13 and 15 have no function
`timescale 1ns/10ps
`default_nettype none
module dpdcs_core import dpdcs_pkg::*; (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // object dictionary access
  input wire logic i_obj_req,
  input wire dpdcs_obj_req_t i_obj,
  output logic o_obj_ack,
  output logic o_obj_err,
  output logic [15:0] o_obj_rdata,
  // command word from receive process data
  input wire logic i_rx_cmd_valid,
  input wire logic [15:0] i_rx_cmd_word,
  // transmit datagram stream
  input wire logic i_dg_start,
  output logic o_dg_valid,
  output logic [7:0] o_dg_byte,
  output logic o_dg_last,
  output logic o_dg_busy,
  // drive application side
  input wire dpdcs_items_t i_items,
  input wire logic i_ext_support,
  input wire dpdcs_flags_t i_flags,
  input wire dpdcs_bypass_t i_bypass,
  input wire logic i_profile_mode,
  input wire logic [1:0] i_drive_ctrl_mode,
  // drive commands
  output logic o_output_voltage_enable,
  output logic o_start_permit,
  output logic o_run_enable_cmd,
  output logic o_quick_stop_bit,
  output logic o_alert_reset_cmd,
  output logic o_fault_reset_cmd
);

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  logic [15:0] cmd_word_reg;
  logic [15:0] cmd_word_next;
  logic [15:0] state_word_reg;
  logic [15:0] state_word_next;
  logic [2:0] tx_count_reg;
  logic [2:0] rx_count_reg;
  logic [15:0] tx_entry_reg [TX_ASSIGN_MAX];
  dpdcs_dg_state_t dg_state_reg;
  logic [2:0] ent_reg;
  logic [7:0] sub_reg;
  logic [7:0] hi_byte_reg;
  logic obj_ack_reg;
  logic obj_err_reg;
  logic [15:0] obj_rdata_reg;
  logic alert_pulse_reg;
  logic fault_pulse_reg;
  logic volt_reg;
  logic permit_reg;
  logic run_reg;
  logic qstop_reg;
  logic dg_valid_reg;
  logic [7:0] dg_byte_reg;
  logic dg_last_reg;

  // object access decode
  logic rd_req;
  logic wr_req;
  logic sub0;
  logic cmd_hit;
  logic state_hit;
  logic tx_asg_hit;
  logic rx_asg_hit;
  logic map_cnt_hit;
  logic cmd_wr_ok;
  logic tx_cnt_wr_ok;
  logic tx_ent_wr_ok;
  logic rx_cnt_wr_ok;
  logic entry_valid;
  logic [2:0] wr_slot;
  logic [2:0] rd_slot;
  logic rd_ok;
  logic [15:0] rd_value;
  logic [15:0] map_count;
  logic [15:0] obj_word;
  logic obj_word_hit;

  assign rd_req = i_obj_req && !i_obj.wr;
  assign wr_req = i_obj_req && i_obj.wr;
  assign sub0 = (i_obj.sub == SUB_ZERO);
  assign cmd_hit = (i_obj.index == IDX_CMD_WORD) && sub0;
  assign state_hit = (i_obj.index == IDX_STATE_WORD) && sub0;
  assign tx_asg_hit = (i_obj.index == IDX_TX_ASSIGN) &&
                      (i_obj.sub <= SUB_TX_ASSIGN);
  assign rx_asg_hit = (i_obj.index == IDX_RX_ASSIGN) && sub0;
  assign wr_slot = i_obj.sub[2:0] - 3'h1;
  assign rd_slot = i_obj.sub[2:0] - 3'h1;
  assign entry_valid = (i_obj.wdata == IDX_MAP_STATE) ||
                       (i_obj.wdata == IDX_MAP_BYPASS) ||
                       ((i_obj.wdata >= IDX_MAP_ITEM1) &&
                        (i_obj.wdata <= IDX_MAP_ITEM4));

  // writes: command word only in profile mode; entries only while count is 0
  assign cmd_wr_ok = wr_req && cmd_hit && i_profile_mode;
  assign tx_cnt_wr_ok = wr_req && tx_asg_hit && sub0 && !o_dg_busy &&
                        (i_obj.wdata <= {13'h0000, SUB_TX_ASSIGN[2:0]});
  assign tx_ent_wr_ok = wr_req && tx_asg_hit && !sub0 && entry_valid &&
                        (tx_count_reg == 3'h0);
  assign rx_cnt_wr_ok = wr_req && rx_asg_hit &&
                        (i_obj.wdata <= {13'h0000, SUB_TX_ASSIGN[2:0]});

  // object sizes reported at sub-index zero of each mapping object
  assign map_cnt_hit = sub0 && ((i_obj.index == IDX_MAP_STATE) ||
                       (i_obj.index == IDX_MAP_BYPASS) ||
                       (i_obj.index == IDX_ITEMS) ||
                       ((i_obj.index >= IDX_MAP_ITEM1) &&
                        (i_obj.index <= IDX_MAP_ITEM4)));
  assign map_count = (i_obj.index == IDX_MAP_STATE) ? {8'h00, SUB_MAP_STATE} :
                     (i_obj.index == IDX_MAP_BYPASS) ? {8'h00, SUB_BYPASS} :
                     (i_obj.index == IDX_ITEMS) ? {8'h00, SUB_ITEMS} :
                     {8'h00, SUB_MAP_ITEMS};

  // read-side selector for item and status map contents
  dpdcs_tx_word_sel u_obj_sel (
    .i_index(i_obj.index),
    .i_sub(i_obj.sub),
    .i_items(i_items),
    .i_ext_support(i_ext_support),
    .i_state_word(state_word_reg),
    .i_bypass(i_bypass),
    .o_word(obj_word),
    .o_hit(obj_word_hit)
  );

  // read mux; the profile words are refused in bypass mode
  assign rd_ok = ((cmd_hit || state_hit) && i_profile_mode) || tx_asg_hit ||
                 rx_asg_hit || map_cnt_hit || obj_word_hit;
  assign rd_value = cmd_hit ? cmd_word_reg :
                    state_hit ? state_word_reg :
                    (tx_asg_hit && sub0) ? {13'h0000, tx_count_reg} :
                    tx_asg_hit ? tx_entry_reg[rd_slot] :
                    rx_asg_hit ? {13'h0000, rx_count_reg} :
                    map_cnt_hit ? map_count : obj_word;

  // one-cycle answer; writes to read-only objects are refused
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      obj_ack_reg <= 1'b0;
      obj_err_reg <= 1'b0;
      obj_rdata_reg <= 16'h0000;
    end else begin
      obj_ack_reg <= i_obj_req;
      obj_err_reg <= i_obj_req && (i_obj.wr ? !(cmd_wr_ok || tx_cnt_wr_ok ||
                     tx_ent_wr_ok || rx_cnt_wr_ok) : !rd_ok);
      obj_rdata_reg <= rd_req && rd_ok ? rd_value : 16'h0000;
    end
  end

  assign o_obj_ack = obj_ack_reg;
  assign o_obj_err = obj_err_reg;
  assign o_obj_rdata = obj_rdata_reg;

  a_items_read_only: assert property (wr_req && (i_obj.index == IDX_ITEMS)
    |=> o_obj_ack && o_obj_err) else $error("item write accepted");
  a_map_four_items: assert property (rd_req && sub0 &&
    (i_obj.index >= IDX_MAP_ITEM1) && (i_obj.index <= IDX_MAP_ITEM4)
    |=> o_obj_rdata == 16'h0004) else $error("map size not four");
  a_ext_items_zero: assert property (rd_req && (i_obj.index == IDX_ITEMS) &&
    (i_obj.sub > 8'h08) && (i_obj.sub <= SUB_ITEMS) && !i_ext_support
    |=> !o_obj_err && o_obj_rdata == 16'h0000)
    else $error("upper item not zeroed");
  a_cmd_bypass_refused: assert property (wr_req && cmd_hit && !i_profile_mode
    |=> o_obj_err && $stable(cmd_word_reg))
    else $error("command written in bypass");

  // assignment objects written by the master
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tx_count_reg <= 3'h0;
      rx_count_reg <= 3'h0;
    end else begin
      if (tx_cnt_wr_ok) tx_count_reg <= i_obj.wdata[2:0];
      if (rx_cnt_wr_ok) rx_count_reg <= i_obj.wdata[2:0];
    end
  end

  // one flop group per assignment entry
  for (genvar g = 0; g < TX_ASSIGN_MAX; g++) begin : g_entry
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        tx_entry_reg[g] <= 16'h0000;
      end else if (tx_ent_wr_ok && (wr_slot == 3'(g))) begin
        tx_entry_reg[g] <= i_obj.wdata;
      end
    end
  end

  a_entry_locked: assert property (wr_req && tx_asg_hit && !sub0 &&
    (tx_count_reg != 3'h0) |=> o_obj_err)
    else $error("entry written while count set");

  // command word: object write wins over the process data copy
  assign cmd_word_next = cmd_wr_ok ? i_obj.wdata :
                         (i_rx_cmd_valid && i_profile_mode) ? i_rx_cmd_word :
                         cmd_word_reg;

  // reset commands are one-cycle pulses on rising edges only
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cmd_word_reg <= CMD_WORD_RESET;
      alert_pulse_reg <= 1'b0;
      fault_pulse_reg <= 1'b0;
    end else begin
      cmd_word_reg <= cmd_word_next;
      alert_pulse_reg <= cmd_word_next[CW_ALERT_RST] &&
                         !cmd_word_reg[CW_ALERT_RST];
      fault_pulse_reg <= cmd_word_next[CW_FAULT_RST] &&
                         !cmd_word_reg[CW_FAULT_RST];
    end
  end

  // level commands; bits 4-6, 8-10, 12-15 decode nothing
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      volt_reg <= 1'b0;
      permit_reg <= 1'b0;
      run_reg <= 1'b0;
      qstop_reg <= 1'b0;
    end else begin
      volt_reg <= i_profile_mode && cmd_word_next[CW_VOLTAGE];
      permit_reg <= i_profile_mode && cmd_word_next[CW_VOLTAGE] &&
                    cmd_word_next[CW_SWITCH_ON];
      run_reg <= i_profile_mode && cmd_word_next[CW_VOLTAGE] &&
                 cmd_word_next[CW_SWITCH_ON] && cmd_word_next[CW_RUN];
      qstop_reg <= i_profile_mode && cmd_word_next[CW_QUICK_STOP];
    end
  end

  assign o_output_voltage_enable = volt_reg;
  assign o_start_permit = permit_reg;
  assign o_run_enable_cmd = run_reg;
  assign o_quick_stop_bit = qstop_reg;
  assign o_alert_reset_cmd = alert_pulse_reg;
  assign o_fault_reset_cmd = fault_pulse_reg;

  a_alert_rise_pulse: assert property ($rose(cmd_word_reg[CW_ALERT_RST])
    |-> o_alert_reset_cmd ##1 !o_alert_reset_cmd)
    else $error("alarm reset pulse wrong");
  a_alert_level_quiet: assert property ($past(cmd_word_reg[CW_ALERT_RST]) &&
    cmd_word_reg[CW_ALERT_RST] |-> !o_alert_reset_cmd)
    else $error("alarm reset on level");
  a_fault_rise_pulse: assert property (o_fault_reset_cmd
    |-> cmd_word_reg[CW_FAULT_RST] && !$past(cmd_word_reg[CW_FAULT_RST]))
    else $error("fault reset without edge");
  a_run_needs_volt: assert property (o_run_enable_cmd
    |-> o_output_voltage_enable && o_start_permit)
    else $error("run without voltage and permit");

  // state word sampled from the drive; unused positions stay zero
  assign state_word_next = {1'b0, (i_drive_ctrl_mode != CTRL_MODE_PROFILE),
    3'b000, i_flags.target_reached, i_flags.remote, 1'b0, i_flags.alarm,
    i_flags.switch_on_disabled, i_flags.quick_stop_active,
    i_flags.voltage_enabled, i_flags.fault, i_flags.op_enabled,
    i_flags.switched_on, i_flags.ready};

  always_ff @(posedge i_clk) begin
    if (i_rst) state_word_reg <= STATE_WORD_RESET;
    else state_word_reg <= state_word_next;
  end

  a_state_unused_zero: assert property ((state_word_reg & SW_UNUSED_MASK)
    == 16'h0000) else $error("unused state bit set");
  a_state_mismatch: assert property (##1 state_word_reg[SW_MISMATCH] ==
    ($past(i_drive_ctrl_mode) != CTRL_MODE_PROFILE))
    else $error("mode mismatch bit wrong");

  // datagram walk over the assigned mapping objects
  logic [15:0] cur_entry;
  logic [7:0] cur_subs;
  logic last_sub;
  logic last_ent;
  logic [15:0] dg_word;

  assign cur_entry = tx_entry_reg[ent_reg];
  assign cur_subs = (cur_entry == IDX_MAP_BYPASS) ? SUB_BYPASS :
                    (cur_entry == IDX_MAP_STATE) ? SUB_MAP_STATE :
                    SUB_MAP_ITEMS;
  assign last_sub = (sub_reg == cur_subs);
  assign last_ent = (ent_reg == tx_count_reg - 3'h1);
  assign o_dg_busy = (dg_state_reg != DG_IDLE);

  dpdcs_tx_word_sel u_dg_sel (
    .i_index(cur_entry),
    .i_sub(sub_reg),
    .i_items(i_items),
    .i_ext_support(i_ext_support),
    .i_state_word(state_word_reg),
    .i_bypass(i_bypass),
    .o_word(dg_word),
    .o_hit()
  );

  // two bytes per item; the high byte is held so the pair stays coherent
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      dg_state_reg <= DG_IDLE;
      ent_reg <= 3'h0;
      sub_reg <= SUB_FIRST;
      hi_byte_reg <= 8'h00;
      dg_valid_reg <= 1'b0;
      dg_byte_reg <= 8'h00;
      dg_last_reg <= 1'b0;
    end else begin
      dg_valid_reg <= 1'b0;
      dg_last_reg <= 1'b0;
      case (dg_state_reg)
        DG_IDLE: begin
          ent_reg <= 3'h0;
          sub_reg <= SUB_FIRST;
          if (i_dg_start && (tx_count_reg != 3'h0)) dg_state_reg <= DG_LOW;
        end
        DG_LOW: begin
          dg_valid_reg <= 1'b1;
          dg_byte_reg <= dg_word[7:0];
          hi_byte_reg <= dg_word[15:8];
          dg_state_reg <= DG_HIGH;
        end
        DG_HIGH: begin
          dg_valid_reg <= 1'b1;
          dg_byte_reg <= hi_byte_reg;
          if (last_sub && last_ent) begin
            dg_last_reg <= 1'b1;
            dg_state_reg <= DG_IDLE;
          end else begin
            dg_state_reg <= DG_LOW;
            if (last_sub) begin
              sub_reg <= SUB_FIRST;
              ent_reg <= ent_reg + 3'h1;
            end else begin
              sub_reg <= sub_reg + 8'h01;
            end
          end
        end
        default: dg_state_reg <= DG_IDLE;
      endcase
    end
  end

  assign o_dg_valid = dg_valid_reg;
  assign o_dg_byte = dg_byte_reg;
  assign o_dg_last = dg_last_reg;

  sequence s_low_byte;
    (dg_state_reg == DG_LOW) ##1 (o_dg_valid && o_dg_byte == $past(dg_word[7:0]));
  endsequence
  sequence s_high_byte;
    o_dg_valid && (o_dg_byte == $past(dg_word[15:8], 2));
  endsequence
  a_dg_byte_order: assert property (s_low_byte |=> s_high_byte)
    else $error("datagram byte order wrong");
  a_dg_start_first: assert property (!o_dg_busy && i_dg_start &&
    (tx_count_reg != 3'h0) |=> (dg_state_reg == DG_LOW) && (ent_reg == 3'h0))
    else $error("walk did not start at entry zero");

endmodule // dpdcs_core
`default_nettype wire

// [verilog/dpdcs_pkg.sv]
// shared constants and types of the drive process data and control/status bank
package dpdcs_pkg;

  // dictionary indexes
  localparam logic [15:0] IDX_ITEMS = 16'h5fff;
  localparam logic [15:0] IDX_CMD_WORD = 16'h6040;
  localparam logic [15:0] IDX_STATE_WORD = 16'h6041;
  localparam logic [15:0] IDX_MAP_STATE = 16'h1a00;
  localparam logic [15:0] IDX_MAP_ITEM1 = 16'h1a01;
  localparam logic [15:0] IDX_MAP_ITEM4 = 16'h1a04;
  localparam logic [15:0] IDX_MAP_BYPASS = 16'h1a10;
  localparam logic [15:0] IDX_RX_ASSIGN = 16'h1c12;
  localparam logic [15:0] IDX_TX_ASSIGN = 16'h1c13;

  // sub-index limits and entry counts
  localparam logic [7:0] SUB_ZERO = 8'h00;
  localparam logic [7:0] SUB_FIRST = 8'h01;
  localparam logic [7:0] SUB_MAP_ITEMS = 8'h04;
  localparam logic [7:0] SUB_BYPASS = 8'h03;
  localparam logic [7:0] SUB_MAP_STATE = 8'h01;
  localparam logic [7:0] SUB_ITEMS = 8'h10;
  localparam logic [7:0] SUB_TX_ASSIGN = 8'h06;
  localparam logic [3:0] ITEM_BASE_LAST = 4'h7;
  localparam int TX_ASSIGN_MAX = 6;

  // command word bit positions
  localparam int CW_SWITCH_ON = 0;
  localparam int CW_VOLTAGE = 1;
  localparam int CW_QUICK_STOP = 2;
  localparam int CW_RUN = 3;
  localparam int CW_FAULT_RST = 7;
  localparam int CW_ALERT_RST = 11;

  // state word layout, reset values and drive control mode
  localparam int SW_MISMATCH = 14;
  localparam logic [15:0] SW_UNUSED_MASK = 16'hb900;
  localparam logic [15:0] CMD_WORD_RESET = 16'h0000;
  localparam logic [15:0] STATE_WORD_RESET = 16'h0000;
  localparam logic [1:0] CTRL_MODE_PROFILE = 2'h0;

  typedef logic [15:0][15:0] dpdcs_items_t;

  typedef struct packed {
    logic ready;
    logic switched_on;
    logic op_enabled;
    logic fault;
    logic voltage_enabled;
    logic quick_stop_active;
    logic switch_on_disabled;
    logic alarm;
    logic remote;
    logic target_reached;
  } dpdcs_flags_t;

  typedef struct packed {
    logic [15:0] fixed_status;
    logic [15:0] general_status;
    logic [15:0] speed_actual;
  } dpdcs_bypass_t;

  typedef struct packed {
    logic wr;
    logic [15:0] index;
    logic [7:0] sub;
    logic [15:0] wdata;
  } dpdcs_obj_req_t;

  typedef enum logic [1:0] {
    DG_IDLE = 2'b00,
    DG_LOW = 2'b01,
    DG_HIGH = 2'b11
  } dpdcs_dg_state_t;

endpackage

// [verilog/dpdcs_tx_word_sel.sv]
// selects one transmit word by mapping or dictionary index and sub-index
`timescale 1ns/10ps
`default_nettype none
module dpdcs_tx_word_sel import dpdcs_pkg::*; (
  // selection
  input wire logic [15:0] i_index,
  input wire logic [7:0] i_sub,
  // sources
  input wire dpdcs_items_t i_items,
  input wire logic i_ext_support,
  input wire logic [15:0] i_state_word,
  input wire dpdcs_bypass_t i_bypass,
  // result
  output logic [15:0] o_word,
  output logic o_hit
);

  // decode of the four item maps, the direct index and the status maps
  logic [15:0] map_ofs;
  logic [7:0] sub_m1;
  logic [3:0] map_item;
  logic [3:0] item_num;
  logic map_hit;
  logic dir_hit;
  logic state_hit;
  logic byp_hit;
  logic item_zero;
  logic [15:0] byp_word;
  logic [15:0] item_word;

  assign map_ofs = i_index - IDX_MAP_ITEM1;
  assign sub_m1 = i_sub - SUB_FIRST;
  assign map_item = {map_ofs[1:0], 2'b00} + {2'b00, sub_m1[1:0]};
  assign map_hit = (i_index >= IDX_MAP_ITEM1) && (i_index <= IDX_MAP_ITEM4) &&
                   (i_sub >= SUB_FIRST) && (i_sub <= SUB_MAP_ITEMS);
  assign dir_hit = (i_index == IDX_ITEMS) && (i_sub >= SUB_FIRST) &&
                   (i_sub <= SUB_ITEMS);
  assign state_hit = (i_index == IDX_MAP_STATE) && (i_sub == SUB_MAP_STATE);
  assign byp_hit = (i_index == IDX_MAP_BYPASS) && (i_sub >= SUB_FIRST) &&
                   (i_sub <= SUB_BYPASS);
  assign item_num = map_hit ? map_item : sub_m1[3:0];

  // items past the base eight read zero when the drive lacks the wide modes
  assign item_zero = (item_num > ITEM_BASE_LAST) && !i_ext_support;
  assign item_word = item_zero ? 16'h0000 : i_items[item_num];

  // bypass status map: fixed word, general word, actual speed
  assign byp_word = (i_sub[1:0] == 2'b01) ? i_bypass.fixed_status :
                    (i_sub[1:0] == 2'b10) ? i_bypass.general_status :
                    i_bypass.speed_actual;

  assign o_hit = map_hit || dir_hit || state_hit || byp_hit;
  assign o_word = (map_hit || dir_hit) ? item_word :
                  state_hit ? i_state_word :
                  byp_hit ? byp_word : 16'h0000;

endmodule // dpdcs_tx_word_sel
`default_nettype wire
